// >>> verilog/power_mgmt_pkg.sv
// Functional notes
// - enable bit 7 passes the supply-restored flag to the shared supply interrupt, reset zero.
// - with enable bit 6 set, reading the three meter status registers also clears them.
// - enable bit 5 passes the sag flag to the shared supply interrupt.
// - enable bit 3 passes the switched-supply flag to the shared supply interrupt.
// - enable bit 2 passes the battery level flag to the shared supply interrupt.
// - enable bit 1 passes the switchover flag to the shared supply interrupt.
// - enable bit 0 passes the dc input flag to the shared supply interrupt.
// - four byte scratch registers read and write freely, reset to zero, kept in all power modes.
// - power control bit 4 shuts the core down only while in the first power-saving mode.
// - power control bits 2..0 divide the 4.096 MHz core clock by two to the field, reset 010.
// - a power control write lands only as the next write after a write of 0xa7 to the key register.
// - supply flags stay latched until software clears them; only enabled ones raise the request.
`default_nettype none
package power_mgmt_pkg;
  localparam logic [7:0] power_control_addr = 8'hc5;
  localparam logic [7:0] supply_irq_enable_addr = 8'hec;
  localparam logic [7:0] scratch_pad_one_addr = 8'hfb;
  localparam logic [7:0] scratch_pad_two_addr = 8'hfc;
  localparam logic [7:0] scratch_pad_three_addr = 8'hfd;
  localparam logic [7:0] scratch_pad_four_addr = 8'hfe;
  // key register address is arbitrary, picked from a free slot of the map
  localparam logic [7:0] write_key_register_addr = 8'hc1;
  localparam logic [7:0] write_key_value = 8'ha7;
  localparam int restored_irq_en_bit = 7;
  localparam int meter_status_clear_on_read_bit = 6;
  localparam int sag_irq_en_bit = 5;
  localparam int reserved_enable_bit = 4;
  localparam int switched_supply_irq_en_bit = 3;
  localparam int battery_level_irq_en_bit = 2;
  localparam int switchover_irq_en_bit = 1;
  localparam int dc_input_irq_en_bit = 0;
  localparam int core_shutdown_bit = 4;
  localparam int core_clock_divider_msb = 2;
  localparam logic [7:0] supply_irq_enable_reset = 8'h00;
  localparam logic [7:0] scratch_reset = 8'h00;
  localparam logic [2:0] core_clock_divider_reset = 3'h2;
  localparam logic [7:0] power_control_mask = 8'h17;
endpackage : power_mgmt_pkg
`default_nettype wire

// >>> verilog/power_mgmt_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_control_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [5:0] supply_flags_in,
  input wire logic first_power_saving_mode_in,
  input wire logic meter_status_read_in,
  output logic meter_status_clear_out,
  output logic supply_monitor_interrupt_out,
  output logic core_shutdown_out,
  output logic [2:0] core_clock_divider_out
);
  import power_mgmt_pkg::*;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] supply_irq_enable_r, supply_irq_enable_nxt;
  logic [7:0] power_control_r, power_control_nxt;
  logic [7:0] scratch_r [4];
  logic [7:0] scratch_nxt [4];
  logic key_armed_r, key_armed_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic [5:0] flags_s1_r, flags_s2_r;
  logic first_power_saving_mode_s1_r, first_power_saving_mode_s2_r;

  // flags and mode come from other logic domains; two stages before use
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flags_s1_r <= 6'h00;
      flags_s2_r <= 6'h00;
      first_power_saving_mode_s1_r <= 1'b0;
      first_power_saving_mode_s2_r <= 1'b0;
    end
    else
    begin
      flags_s1_r <= supply_flags_in;
      flags_s2_r <= flags_s1_r;
      first_power_saving_mode_s1_r <= first_power_saving_mode_in;
      first_power_saving_mode_s2_r <= first_power_saving_mode_s1_r;
    end
  end

  // write decode, key handling and read mux
  always_comb
  begin
    supply_irq_enable_nxt = supply_irq_enable_r;
    power_control_nxt = power_control_r;
    for (int i = 0; i < 4; i++)
      scratch_nxt[i] = scratch_r[i];
    key_armed_nxt = key_armed_r;
    rdata_nxt = rdata_r;
    if (reg_wr_in)
    begin
      // any write disarms; only the key value rearms
      key_armed_nxt = (reg_addr_in == write_key_register_addr) &&
                      (reg_wdata_in == write_key_value);
      case (reg_addr_in)
        supply_irq_enable_addr: supply_irq_enable_nxt = reg_wdata_in;
        power_control_addr:
          if (key_armed_r)
            power_control_nxt = reg_wdata_in & power_control_mask;
        scratch_pad_one_addr: scratch_nxt[0] = reg_wdata_in;
        scratch_pad_two_addr: scratch_nxt[1] = reg_wdata_in;
        scratch_pad_three_addr: scratch_nxt[2] = reg_wdata_in;
        scratch_pad_four_addr: scratch_nxt[3] = reg_wdata_in;
        default: ;
      endcase
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        supply_irq_enable_addr: rdata_nxt = supply_irq_enable_r;
        power_control_addr: rdata_nxt = power_control_r;
        scratch_pad_one_addr: rdata_nxt = scratch_r[0];
        scratch_pad_two_addr: rdata_nxt = scratch_r[1];
        scratch_pad_three_addr: rdata_nxt = scratch_r[2];
        scratch_pad_four_addr: rdata_nxt = scratch_r[3];
        default: rdata_nxt = 8'h00;
      endcase
    end
    // flags latch outside; request is or of enabled sources
    irq_nxt = (supply_irq_enable_r[restored_irq_en_bit] & flags_s2_r[5]) |
              (supply_irq_enable_r[sag_irq_en_bit] & flags_s2_r[4]) |
              (supply_irq_enable_r[switched_supply_irq_en_bit] & flags_s2_r[3]) |
              (supply_irq_enable_r[battery_level_irq_en_bit] & flags_s2_r[2]) |
              (supply_irq_enable_r[switchover_irq_en_bit] & flags_s2_r[1]) |
              (supply_irq_enable_r[dc_input_irq_en_bit] & flags_s2_r[0]);
  end

  // registers; scratch has only the synchronous reset, no power-mode clear
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      supply_irq_enable_r <= supply_irq_enable_reset;
      power_control_r <= {5'h00, core_clock_divider_reset};
      for (int i = 0; i < 4; i++)
        scratch_r[i] <= scratch_reset;
      key_armed_r <= 1'b0;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end
    else
    begin
      supply_irq_enable_r <= supply_irq_enable_nxt;
      power_control_r <= power_control_nxt;
      for (int i = 0; i < 4; i++)
        scratch_r[i] <= scratch_nxt[i];
      key_armed_r <= key_armed_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  // outputs
  assign reg_rdata_out = rdata_r;
  assign supply_monitor_interrupt_out = irq_r;
  // meter front end clears its status on its own read strobe, only while enable bit 6 is set
  assign meter_status_clear_out = meter_status_read_in &
                                  supply_irq_enable_r[meter_status_clear_on_read_bit];
  assign core_shutdown_out = power_control_r[core_shutdown_bit] & first_power_saving_mode_s2_r;
  assign core_clock_divider_out = power_control_r[core_clock_divider_msb:0];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_key_gate;
    @(posedge clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == power_control_addr && !key_armed_r) |=>
      $stable(power_control_r);
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("unkeyed power write landed");

  // armed power write lands, with idle or read cycles allowed after the key
  property p_key_write;
    @(posedge clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == power_control_addr && key_armed_r) |=>
      power_control_r == ($past(reg_wdata_in) & power_control_mask);
  endproperty
  a_key_write: assert property (p_key_write) else $error("keyed power write lost");

  property p_key_arm;
    @(posedge clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == write_key_register_addr && reg_wdata_in == write_key_value)
      |=> key_armed_r;
  endproperty
  a_key_arm: assert property (p_key_arm) else $error("key write did not arm");

  property p_key_disarm;
    @(posedge clk_in) disable iff (rst_in)
    (reg_wr_in && !(reg_addr_in == write_key_register_addr && reg_wdata_in == write_key_value))
      |=> !key_armed_r;
  endproperty
  a_key_disarm: assert property (p_key_disarm) else $error("key stayed armed");

  property p_restored;
    @(posedge clk_in) disable iff (rst_in)
    (supply_irq_enable_r[restored_irq_en_bit] && flags_s2_r[5]) |=> irq_r;
  endproperty
  a_restored: assert property (p_restored) else $error("restored irq missing");

  property p_sag;
    @(posedge clk_in) disable iff (rst_in)
    (supply_irq_enable_r[sag_irq_en_bit] && flags_s2_r[4]) |=> irq_r;
  endproperty
  a_sag: assert property (p_sag) else $error("sag irq missing");

  property p_switched;
    @(posedge clk_in) disable iff (rst_in)
    (supply_irq_enable_r[switched_supply_irq_en_bit] && flags_s2_r[3]) |=> irq_r;
  endproperty
  a_switched: assert property (p_switched) else $error("switched irq missing");

  property p_battery;
    @(posedge clk_in) disable iff (rst_in)
    (supply_irq_enable_r[battery_level_irq_en_bit] && flags_s2_r[2]) |=> irq_r;
  endproperty
  a_battery: assert property (p_battery) else $error("battery irq missing");

  property p_switchover;
    @(posedge clk_in) disable iff (rst_in)
    (supply_irq_enable_r[switchover_irq_en_bit] && flags_s2_r[1]) |=> irq_r;
  endproperty
  a_switchover: assert property (p_switchover) else $error("switchover irq missing");

  property p_dc_input;
    @(posedge clk_in) disable iff (rst_in)
    (supply_irq_enable_r[dc_input_irq_en_bit] && flags_s2_r[0]) |=> irq_r;
  endproperty
  a_dc_input: assert property (p_dc_input) else $error("dc input irq missing");

  property p_masked;
    @(posedge clk_in) disable iff (rst_in)
    (({supply_irq_enable_r[restored_irq_en_bit], supply_irq_enable_r[sag_irq_en_bit],
       supply_irq_enable_r[switched_supply_irq_en_bit:dc_input_irq_en_bit]} &
      flags_s2_r) == 6'h00) |=> !irq_r;
  endproperty
  a_masked: assert property (p_masked) else $error("irq without enabled flag");

  property p_shutdown;
    @(posedge clk_in) disable iff (rst_in)
    !first_power_saving_mode_in |-> ##2 !core_shutdown_out;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown outside mode");

  // mode pin takes two synchroniser stages before it can shut the core
  property p_shutdown_on;
    @(posedge clk_in) disable iff (rst_in)
    first_power_saving_mode_in ##2 power_control_r[core_shutdown_bit] |-> core_shutdown_out;
  endproperty
  a_shutdown_on: assert property (p_shutdown_on) else $error("shutdown not taken");

  property p_clear_on_read;
    @(posedge clk_in) disable iff (rst_in)
    meter_status_clear_out ==
      (meter_status_read_in && supply_irq_enable_r[meter_status_clear_on_read_bit]);
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("status clear wrong");

  property p_scratch;
    @(posedge clk_in) disable iff (rst_in)
    (reg_wr_in && reg_addr_in == scratch_pad_one_addr) |=>
      scratch_r[0] == $past(reg_wdata_in);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch write lost");

  property p_scratch_read;
    @(posedge clk_in) disable iff (rst_in)
    (reg_rd_in && reg_addr_in == scratch_pad_one_addr) |=>
      reg_rdata_out == $past(scratch_r[0]);
  endproperty
  a_scratch_read: assert property (p_scratch_read) else $error("scratch readback wrong");
endmodule : power_mgmt_control_regs
`default_nettype wire

// >>> tb/supply_flag_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// supply event flags outside the block
// ----------------------------------------
module supply_flag_model (
  input wire logic clk_in,
  input wire logic [5:0] set_in,
  input wire logic [5:0] clear_in,
  output logic [5:0] flags_out
);
  // flags stay up until software clears them, so a short event is never lost
  logic [5:0] flags_r = 6'h00;
  // an event in the clearing cycle wins, so it is not lost
  always @(posedge clk_in)
  begin
    flags_r <= (flags_r & ~clear_in) | set_in;
  end
  assign flags_out = flags_r;
endmodule : supply_flag_model
`default_nettype wire

// >>> tb/power_mgmt_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module power_mgmt_control_regs_tb;
  import power_mgmt_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mode = 1'b0;
  logic mread = 1'b0;
  logic [5:0] fset = 6'h00;
  logic [5:0] fclr = 6'h00;
  logic [5:0] flags;
  logic [7:0] rdata;
  logic mclr;
  logic irq;
  logic shut;
  logic [2:0] div;
  int errors = 0;
  int samples_checked = 0;
  // enable bit that gates each flag input
  int en_bit [6] = '{0, 1, 2, 3, 5, 7};
  always #2 clk_in = ~clk_in;
  supply_flag_model flag_src (.clk_in(clk_in), .set_in(fset), .clear_in(fclr), .flags_out(flags));
  power_mgmt_control_regs dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .supply_flags_in(flags), .first_power_saving_mode_in(mode), .meter_status_read_in(mread),
    .meter_status_clear_out(mclr), .supply_monitor_interrupt_out(irq),
    .core_shutdown_out(shut), .core_clock_divider_out(div));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  // an idle edge after each access keeps strobes from toggling twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_in);
    #1 wr = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string nm);
    addr = a;
    rd = 1'b1;
    @(posedge clk_in);
    #1 rd = 1'b0;
    `chk(nm, e, rdata)
    @(posedge clk_in);
    #1;
  endtask : rd_reg
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : waitc
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    waitc(16);
    rst_in = 1'b0;
    `chk("divider", 3'h2, div)
    rd_reg(8'hec, 8'h00, "enable");
    rd_reg(8'hc5, 8'h02, "power_control");
    rd_reg(8'h10, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(8'hfb + i[7:0], 8'h00, "scratch reset");
      wr_reg(8'hfb + i[7:0], 8'h5a ^ i[7:0]);
    end
    mode = 1'b1;
    for (int i = 0; i < 4; i++)
      rd_reg(8'hfb + i[7:0], 8'h5a ^ i[7:0], "scratch");
    $display("test registers done");
    // lone and disarmed writes must both be dropped
    wr_reg(8'hc5, 8'h14);
    rd_reg(8'hc5, 8'h02, "unkeyed");
    wr_reg(8'hc1, 8'ha7);
    wr_reg(8'hfb, 8'h00);
    wr_reg(8'hc5, 8'h14);
    rd_reg(8'hc5, 8'h02, "disarmed");
    mode = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(8'hc1, 8'ha7);
      wr_reg(8'hc5, 8'hf8 | i[7:0]);
      `chk("divider", i[2:0], div)
      `chk("shutdown off", 1'b0, shut)
      rd_reg(8'hc5, 8'h10 | i[7:0], "power_control");
    end
    mode = 1'b1;
    waitc(4);
    `chk("shutdown on", 1'b1, shut)
    $display("test key done");
    for (int j = 0; j < 6; j++)
    begin
      wr_reg(8'hec, 8'hef ^ (8'h01 << en_bit[j]));
      fset = 6'h01 << j;
      waitc(1);
      fset = 6'h00;
      waitc(4);
      `chk("irq masked", 1'b0, irq)
      wr_reg(8'hec, 8'h01 << en_bit[j]);
      waitc(2);
      `chk("irq", 1'b1, irq)
      fclr = 6'h3f;
      waitc(1);
      fclr = 6'h00;
      waitc(4);
      `chk("irq cleared", 1'b0, irq)
    end
    $display("test interrupt done");
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(8'hec, k[0] ? 8'h40 : 8'h00);
      rd_reg(8'hec, k[0] ? 8'h40 : 8'h00, "enable");
      mread = 1'b1;
      #1 `chk("clear on read", k[0], mclr)
      mread = 1'b0;
    end
    $display("test clear on read done");
    summarize();
  end
  // cut a hang short well beyond the expected run of under a thousand ns
  initial
  begin
    #40000;
    errors++;
    summarize();
  end
endmodule : power_mgmt_control_regs_tb
`default_nettype wire
